// file: hw/tuner_serial_control.sv
/*
  Top of the tuner serial control logic: two-wire slave on the link clock,
  status, power-on flag, lock, ports, bypass and power-down in the core clock.
  Assumes an open-drain data line resolved outside and a free running link clock
  fast enough to oversample the bus clock at least eight times.
*/
`timescale 1ns/100ps
module tuner_serial_control
  import tuner_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectHi,
  input wire logic addrSelectLo,
  input wire logic standbyIn,
  input wire logic lockIn,
  input wire logic supplyFailIn,
  output logic lockPin,
  output logic analogPowerDown,
  output logic bypassEnable,
  output logic bypassPowerDown,
  output logic portZeroOut,
  output logic portZeroOe,
  output logic portOneOut,
  output logic portOneOe,
  output logic [14:0] progDivider,
  output logic [4:0] synthRefRatio,
  output logic [4:0] filterRefDivider,
  output logic [5:0] filterBandwidthField,
  output logic [1:0] loBand,
  output logic [7:0] tunerStatus
);
  import tuner_ctrl_pkg::*;

  cfg_bus_if bus ();

  cfg_reg_bank u_bank (
    .clk(clk),
    .resetn(resetn),
    .bus(bus.bank)
  );

  // Link domain synchronisers
  logic linkRst1_q, linkRstn_q;
  logic scl1_q, scl2_q, sclPrev_q;
  logic sda1_q, sda2_q, sdaPrev_q;
  logic [1:0] sel1_q, sel2_q;
  logic [7:0] stat1_q, stat2_q;

  always_ff @(posedge linkClk) begin
    linkRst1_q <= resetn;
    linkRstn_q <= linkRst1_q;
    scl1_q <= sclIn;
    scl2_q <= scl1_q;
    sclPrev_q <= scl2_q;
    sda1_q <= sdaIn;
    sda2_q <= sda1_q;
    sdaPrev_q <= sda2_q;
    sel1_q <= {addrSelectHi, addrSelectLo};
    sel2_q <= sel1_q;
    // Status bits are quasi static, so a per-bit synchroniser is enough
    stat1_q <= tunerStatus;
    stat2_q <= stat1_q;
  end

  logic sclRise, sclFall, startCond, stopCond;
  assign sclRise = scl2_q && !sclPrev_q;
  assign sclFall = !scl2_q && sclPrev_q;
  assign startCond = scl2_q && sclPrev_q && sdaPrev_q && !sda2_q;
  assign stopCond = scl2_q && sclPrev_q && !sdaPrev_q && sda2_q;

  // Link engine
  link_state_type state_q;
  logic [7:0] shift_q;
  logic [3:0] bitCnt_q;
  logic readMode_q, firstPending_q, masterAck_q, sdaLow_q;
  logic [7:0] wrData_q;
  logic wrFirst_q, wrTog_q, porClrTog_q;
  logic addrMatch;

  assign addrMatch = shift_q[7:3] == ADDR_FIXED && shift_q[2:1] == sel2_q;

  always_ff @(posedge linkClk) begin
    if (!linkRstn_q) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      readMode_q <= 1'b0;
      firstPending_q <= 1'b0;
      masterAck_q <= 1'b0;
      sdaLow_q <= 1'b0;
      wrData_q <= 8'h00;
      wrFirst_q <= 1'b0;
      wrTog_q <= 1'b0;
      porClrTog_q <= 1'b0;
    end else if (startCond) begin
      state_q <= ST_ADDR;
      bitCnt_q <= 4'h0;
      sdaLow_q <= 1'b0;
    end else if (stopCond) begin
      // read ended by stop clears power-on flag
      if (readMode_q && state_q != ST_IDLE) begin
        porClrTog_q <= !porClrTog_q;
      end
      state_q <= ST_IDLE;
      readMode_q <= 1'b0;
      sdaLow_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WRITE: begin
          if (sclRise) begin
            shift_q <= {shift_q[6:0], sda2_q};
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_q <= 4'h0;
            if (state_q == ST_WRITE) begin
              wrData_q <= shift_q;
              wrFirst_q <= firstPending_q;
              firstPending_q <= 1'b0;
              wrTog_q <= !wrTog_q;
              sdaLow_q <= 1'b1;
              state_q <= ST_WRITE_ACK;
            end else if (addrMatch) begin
              readMode_q <= shift_q[0];
              firstPending_q <= 1'b1;
              sdaLow_q <= 1'b1;
              state_q <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK, ST_WRITE_ACK: begin
          if (sclFall) begin
            if (readMode_q) begin
              shift_q <= stat2_q;
              sdaLow_q <= !stat2_q[7];
              state_q <= ST_READ;
            end else begin
              sdaLow_q <= 1'b0;
              state_q <= ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (sclRise) begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end else if (sclFall) begin
            if (bitCnt_q == 4'h8) begin
              bitCnt_q <= 4'h0;
              sdaLow_q <= 1'b0;
              state_q <= ST_MASTER_ACK;
            end else begin
              shift_q <= {shift_q[6:0], 1'b0};
              sdaLow_q <= !shift_q[6];
            end
          end
        end
        ST_MASTER_ACK: begin
          if (sclRise) begin
            masterAck_q <= !sda2_q;
          end else if (sclFall) begin
            if (masterAck_q) begin
              shift_q <= stat2_q;
              sdaLow_q <= !stat2_q[7];
              state_q <= ST_READ;
            end else begin
              state_q <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          sdaLow_q <= 1'b0;
        end
        default: begin
          sdaLow_q <= 1'b0;
        end
      endcase
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = sdaLow_q;

  // Core domain: event toggles and levels crossing in
  logic wrT1_q, wrT2_q, wrT3_q, clrT1_q, clrT2_q, clrT3_q;
  logic std1_q, std2_q, lck1_q, lck2_q, sf1_q, sf2_q;
  logic por_q;
  logic [7:0] status_q;
  logic porClear;

  always_ff @(posedge clk) begin
    wrT1_q <= wrTog_q;
    wrT2_q <= wrT1_q;
    wrT3_q <= wrT2_q;
    clrT1_q <= porClrTog_q;
    clrT2_q <= clrT1_q;
    clrT3_q <= clrT2_q;
    std1_q <= standbyIn;
    std2_q <= std1_q;
    lck1_q <= lockIn;
    lck2_q <= lck1_q;
    sf1_q <= supplyFailIn;
    sf2_q <= sf1_q;
  end

  // Write data is held for a whole byte time, far longer than the toggle sync
  assign bus.wrStrobe = wrT2_q ^ wrT3_q;
  assign bus.wrData = wrData_q;
  assign bus.wrFirst = wrFirst_q;
  assign porClear = clrT2_q ^ clrT3_q;

  assign bus.reload = sf2_q;

  // power-on flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!resetn || sf2_q) begin
      por_q <= 1'b1;
    end else if (porClear) begin
      por_q <= 1'b0;
    end
  end

  logic [14:0] divider;
  logic pwrBit, bypassOff;
  assign divider = {bus.cfgBytes[DIV_HI_IDX][6:0], bus.cfgBytes[DIV_LO_IDX]};
  assign pwrBit = bus.cfgBytes[PWR_IDX][PWR_BIT];
  assign bypassOff = bus.cfgBytes[BYPASS_IDX][BYPASS_OFF_BIT];

  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_q <= 8'h00;
      lockPin <= 1'b0;
      analogPowerDown <= 1'b0;
      bypassEnable <= 1'b1;
      bypassPowerDown <= 1'b0;
      portZeroOe <= 1'b0;
      portOneOe <= 1'b0;
      progDivider <= 15'h0000;
      synthRefRatio <= 5'h00;
      filterRefDivider <= 5'h00;
      filterBandwidthField <= 6'h00;
      loBand <= BAND_LOW;
    end else begin
      lockPin <= lck2_q;
      analogPowerDown <= std2_q | pwrBit;
      // bypass from its own bit only
      bypassEnable <= !bypassOff;
      bypassPowerDown <= bypassOff;
      portZeroOe <= bus.cfgBytes[PORT_ZERO_IDX][PORT_BIT];
      portOneOe <= bus.cfgBytes[PORT_ONE_IDX][PORT_BIT];
      progDivider <= divider;
      synthRefRatio <= bus.cfgBytes[SYN_REF_IDX][4:0];
      filterRefDivider <= bus.cfgBytes[FREF_IDX][FREF_LSB +: 5];
      filterBandwidthField <= bus.cfgBytes[BW_IDX][BW_LSB +: 6];
      if (divider >= BAND_EDGE_HIGH) begin
        loBand <= BAND_HIGH;
      end else if (divider >= BAND_EDGE_MID) begin
        loBand <= BAND_MID;
      end else begin
        loBand <= BAND_LOW;
      end
      status_q <= {por_q, lck2_q, analogPowerDown, bypassPowerDown, 4'h0};
    end
  end

  assign portZeroOut = 1'b0;
  assign portOneOut = 1'b0;
  assign tunerStatus = status_q;

  // Core domain checks
  // supply failure sets flag
  a_por_on_fail: assert property (@(posedge clk) disable iff (!resetn)
    sf2_q |=> por_q)
    else $error("power-on flag not set after supply failure");

  // flag falls only on read stop
  a_por_clear_cause: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && $fell(por_q) |-> $past(porClear) && !$past(sf2_q))
    else $error("power-on flag cleared without read stop");

  // flag set after fail means defaults
  a_por_defaults: assert property (@(posedge clk) disable iff (!resetn)
    sf2_q |=> bus.cfgBytes == CFG_RESET)
    else $error("configuration not at defaults with power-on flag set");

  a_sleep_or_bit: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> analogPowerDown == ($past(std2_q) | $past(pwrBit)))
    else $error("analogue power-down differs from standby OR bit");

  a_bypass_own_bit: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) && $stable(bypassOff) ##1 1'b1 |-> $stable(bypassEnable))
    else $error("bypass changed without its control bit");

  // port pulls low only with bit set
  a_port_drive: assert property (@(posedge clk) disable iff (!resetn)
    ##1 portZeroOe == $past(bus.cfgBytes[PORT_ZERO_IDX][PORT_BIT]))
    else $error("port zero enable differs from its control bit");

  a_lock_pin_flag: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |=> tunerStatus[LOCK_BIT] == lockPin)
    else $error("lock flag and lock pin disagree");

  // Link domain checks
  sequence s_addr_match;
    state_q == ST_ADDR && sclFall && bitCnt_q == 4'h8 && addrMatch && !startCond && !stopCond;
  endsequence

  a_addr_ack_low: assert property (@(posedge linkClk) disable iff (!linkRstn_q)
    s_addr_match |=> sdaOe && state_q == ST_ADDR_ACK)
    else $error("no acknowledge after matching address");

  a_dir_from_lsb: assert property (@(posedge linkClk) disable iff (!linkRstn_q)
    s_addr_match |=> readMode_q == $past(shift_q[0]))
    else $error("transfer direction not taken from address bit 0");

  sequence s_master_nack;
    state_q == ST_MASTER_ACK && sclFall && !masterAck_q && !startCond && !stopCond;
  endsequence

  a_nack_release: assert property (@(posedge linkClk) disable iff (!linkRstn_q)
    s_master_nack |=> state_q == ST_HOLD && !sdaOe)
    else $error("data line not released after missing acknowledge");

  a_read_repeats: assert property (@(posedge linkClk) disable iff (!linkRstn_q)
    state_q == ST_MASTER_ACK && sclFall && masterAck_q && !startCond && !stopCond
    |=> state_q == ST_READ && shift_q == $past(stat2_q))
    else $error("status byte not resent after acknowledge");

endmodule

// file: hw/tuner_ctrl_pkg.sv
/*
  Constants, register layout and state type of the tuner serial control logic.
  Assumes a two-wire bus sampled by a free running link clock and a 40 MHz core clock.
*/
package tuner_ctrl_pkg;

  localparam logic [4:0] ADDR_FIXED = 5'h18;
  localparam logic [3:0] CFG_FIRST = 4'h2;
  localparam logic [3:0] CFG_LAST = 4'hD;
  localparam int CFG_COUNT = 12;
  localparam logic [CFG_COUNT*8-1:0] CFG_RESET = {
    8'h28, 8'hF0, 8'h75, 8'hE1, 8'h30, 8'hDB,
    8'h20, 8'hC0, 8'h00, 8'h80, 8'h00, 8'h00};

  localparam int DIV_HI_IDX = 0;
  localparam int DIV_LO_IDX = 1;
  localparam int SYN_REF_IDX = 3;
  localparam int PORT_ZERO_IDX = 3;
  localparam int BYPASS_IDX = 4;
  localparam int PORT_ONE_IDX = 5;
  localparam int BW_IDX = 5;
  localparam int PWR_IDX = 11;
  localparam int FREF_IDX = 11;
  localparam int PORT_BIT = 7;
  localparam int BYPASS_OFF_BIT = 0;
  localparam int PWR_BIT = 7;
  localparam int BW_LSB = 1;
  localparam int FREF_LSB = 2;

  localparam logic [3:0] SEL_BYTE2 = 4'h2;
  localparam logic [3:0] SEL_BYTE4 = 4'h4;
  localparam logic [3:0] SEL_BYTE6 = 4'h6;

  localparam int POR_BIT = 7;
  localparam int LOCK_BIT = 6;
  localparam logic [14:0] BAND_EDGE_MID = 15'h0500;
  localparam logic [14:0] BAND_EDGE_HIGH = 15'h0700;
  localparam logic [1:0] BAND_LOW = 2'h0;
  localparam logic [1:0] BAND_MID = 2'h1;
  localparam logic [1:0] BAND_HIGH = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_MASTER_ACK, ST_HOLD
  } link_state_type;

endpackage

// file: hw/cfg_bus_if.sv
/*
  Interface between the serial front end and the configuration register bank.
  Assumes strobe and reload are in the core clock domain; data and first flag are held link clock registers.
*/
`timescale 1ns/100ps
interface cfg_bus_if;
  logic wrStrobe;
  logic wrFirst;
  logic [7:0] wrData;
  logic reload;
  logic [11:0][7:0] cfgBytes;
  modport source (output wrStrobe, output wrFirst, output wrData, output reload,
                  input cfgBytes);
  modport bank (input wrStrobe, input wrFirst, input wrData, input reload,
                output cfgBytes);
endinterface

// file: hw/cfg_reg_bank.sv
/*
  Twelve writable configuration bytes with pair selection and power-up defaults.
  Assumes one write strobe per received data byte, in the core clock domain.
*/
`timescale 1ns/100ps
module cfg_reg_bank
  import tuner_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  cfg_bus_if.bank bus
);
  import tuner_ctrl_pkg::*;

  logic [3:0] ptr_q;
  logic [3:0] target;
  logic [3:0] pairSel;

  always_comb begin
    if (!bus.wrData[7]) begin
      pairSel = SEL_BYTE2;
    end else if (!bus.wrData[6]) begin
      pairSel = SEL_BYTE4;
    end else begin
      pairSel = SEL_BYTE6 + {1'b0, bus.wrData[5:4], 1'b0};
    end
    target = bus.wrFirst ? pairSel : ptr_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn || bus.reload) begin
      ptr_q <= CFG_LAST + 4'h1;
    end else if (bus.wrStrobe && target <= CFG_LAST) begin
      ptr_q <= target + 4'h1;
    end
  end

  for (genvar i = 0; i < CFG_COUNT; i++) begin : gByte
    always_ff @(posedge clk) begin
      if (!resetn || bus.reload) begin
        bus.cfgBytes[i] <= CFG_RESET[i*8 +: 8];
      end else if (bus.wrStrobe && target == CFG_FIRST + 4'(i)) begin
        bus.cfgBytes[i] <= bus.wrData;
      end
    end
  end

  a_ignore_past_end: assert property (@(posedge clk) disable iff (!resetn)
    bus.wrStrobe && !bus.wrFirst && ptr_q > CFG_LAST && !bus.reload
    |=> $stable(bus.cfgBytes))
    else $error("config changed by write past last register");

  // first byte lands on selected even register
  a_first_lands_even: assert property (@(posedge clk) disable iff (!resetn)
    bus.wrStrobe && bus.wrFirst && !bus.reload
    |=> bus.cfgBytes[pairSel - CFG_FIRST] == $past(bus.wrData))
    else $error("first data byte not stored at selected even register");

endmodule

// file: tb/bus_master_model.sv
/*
  Behavioural two-wire bus master that writes configuration and reads status.
  Assumes the bench resolves the open-drain data line with a pull-up and that
  the link clock runs free; the bus clock only moves inside frames.
*/
`timescale 1ns/100ps
module bus_master_model (
  input wire logic linkClk,
  input wire logic sdaLine,
  output logic sclOut,
  output logic sdaLowOe,
  output logic resValid,
  output logic [7:0] resVal
);
  initial begin
    sclOut = 1'b1;
    sdaLowOe = 1'b0;
    resValid = 1'b0;
    resVal = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge linkClk);
      #1;
    end
  endtask

  task automatic post(input logic [7:0] v);
    resVal = v;
    resValid = 1'b1;
    tick(1);
    resValid = 1'b0;
  endtask

  // Each half period is eight link cycles, twice the minimum the sampler needs
  task automatic bitOut(input logic b);
    sdaLowOe = ~b;
    tick(4);
    sclOut = 1'b1;
    tick(8);
    sclOut = 1'b0;
    tick(4);
  endtask

  task automatic bitIn(output logic b);
    sdaLowOe = 1'b0;
    tick(4);
    sclOut = 1'b1;
    tick(4);
    b = sdaLine;
    tick(4);
    sclOut = 1'b0;
    tick(4);
  endtask

  task automatic start();
    sdaLowOe = 1'b0;
    tick(4);
    sclOut = 1'b1;
    tick(4);
    sdaLowOe = 1'b1;
    tick(4);
    sclOut = 1'b0;
    tick(4);
  endtask

  task automatic stop();
    sdaLowOe = 1'b1;
    tick(4);
    sclOut = 1'b1;
    tick(4);
    sdaLowOe = 1'b0;
    tick(8);
  endtask

  // Bytes sent MSB first as given
  task automatic wrByte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitOut(b[i]);
    end
    bitIn(a);
    post({7'h00, a});
  endtask

  // Master acknowledge asks for another byte
  task automatic rdByte(input bit ackIt);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) begin
      bitIn(v[i]);
    end
    post(v);
    bitOut(~ackIt);
  endtask

  task automatic probe();
    logic b;
    bitIn(b);
    post({7'h00, b});
  endtask
endmodule

// file: tb/tb_top.sv
/*
  Self-checking bench for the tuner serial control logic.
  Assumes the bus master model in its own file; bus results are matched to a queue.
*/
`timescale 1ns/100ps
module tb_top;
  import tuner_ctrl_pkg::*;
  logic clk, resetn, linkClk, sclIn, sdaLine, addrSelectHi, addrSelectLo;
  logic standbyIn, lockIn, supplyFailIn, sdaOut, sdaOe, lockPin, analogPowerDown;
  logic bypassEnable, bypassPowerDown, portZeroOut, portZeroOe, portOneOut, portOneOe;
  logic [14:0] progDivider, div;
  logic [4:0] synthRefRatio, filterRefDivider, br;
  logic [5:0] filterBandwidthField, bw;
  logic [1:0] loBand;
  logic [7:0] tunerStatus, resVal, devW;
  logic sdaLowOe, resValid;
  logic [7:0] expQ[$];
  logic [14:0] edges [3] = '{15'h0100, BAND_EDGE_MID, BAND_EDGE_HIGH};
  logic [1:0] bands [3] = '{BAND_LOW, BAND_MID, BAND_HIGH};
  logic [31:0] rnd = 32'h0001_7044;
  int nFail = 0;
  int testsRun = 0;
  int cycles = 0;

  assign sdaLine = ~(sdaLowOe | (sdaOe & ~sdaOut));

  tuner_serial_control dut (.clk(clk), .resetn(resetn), .linkClk(linkClk), .sclIn(sclIn),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectHi(addrSelectHi),
    .addrSelectLo(addrSelectLo), .standbyIn(standbyIn), .lockIn(lockIn),
    .supplyFailIn(supplyFailIn), .lockPin(lockPin), .analogPowerDown(analogPowerDown),
    .bypassEnable(bypassEnable), .bypassPowerDown(bypassPowerDown),
    .portZeroOut(portZeroOut), .portZeroOe(portZeroOe), .portOneOut(portOneOut),
    .portOneOe(portOneOe), .progDivider(progDivider), .synthRefRatio(synthRefRatio),
    .filterRefDivider(filterRefDivider), .filterBandwidthField(filterBandwidthField),
    .loBand(loBand), .tunerStatus(tunerStatus));

  bus_master_model m (.linkClk(linkClk), .sdaLine(sdaLine), .sclOut(sclIn),
    .sdaLowOe(sdaLowOe), .resValid(resValid), .resVal(resVal));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Odd start offset keeps the link clock out of phase with the core clock
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reportAndStop();
    if (nFail == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      nFail++;
      reportAndStop();
    end
  end

  always @(posedge linkClk) begin
    if (resValid === 1'b1) begin
      if (expQ.size() == 0) check("unexpected bus result", 16'h0001, 16'h0000);
      else check("bus result", {8'h00, resVal}, {8'h00, expQ.pop_front()});
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] lfsrNext(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic stepRand();
    rnd = lfsrNext(rnd);
  endtask

  task automatic wrTx(input logic [7:0] a, input logic [7:0] d [], input bit match);
    m.start();
    expQ.push_back(match ? 8'h00 : 8'h01);
    m.wrByte(a);
    if (match) foreach (d[i]) begin
      expQ.push_back(8'h00);
      m.wrByte(d[i]);
    end
    m.stop();
    cyc(12);
  endtask

  task automatic rdTx(input int n, input logic [7:0] s);
    m.start();
    expQ.push_back(8'h00);
    m.wrByte(devW | 8'h01);
    for (int i = 0; i < n; i++) begin
      expQ.push_back(s);
      m.rdByte(i < n - 1);
    end
    expQ.push_back(8'h01);
    m.probe();
    m.stop();
    cyc(12);
  endtask

  initial begin
    resetn = 1'b0;
    {addrSelectHi, addrSelectLo} = 2'b00;
    standbyIn = 1'b0;
    lockIn = 1'b1;
    supplyFailIn = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    cyc(8);
    check("bypass", {bypassEnable, bypassPowerDown, analogPowerDown}, 3'b100);
    check("ports", {portZeroOe, portOneOe, portZeroOut, portOneOut}, 4'h0);
    check("fields", {filterRefDivider, filterBandwidthField}, {5'h0A, 6'h10});
    check("divider", {progDivider, synthRefRatio, loBand}, 22'h00_0000);
    check("status", tunerStatus, 8'hC0);
    check("lock pin", lockPin, 1'b1);
    for (int s = 0; s < 4; s++) begin
      {addrSelectHi, addrSelectLo} = s[1:0];
      devW = 8'hC0 + 8'(2 * s);
      wrTx(8'hC0 + 8'(2 * ((s + 1) % 4)), '{8'h00, 8'h00}, 1'b0);
      wrTx(devW, '{8'h00, 8'h00}, 1'b1);
    end
    rdTx(3, 8'hC0);
    cyc(8);
    check("por cleared", tunerStatus, 8'h40);
    for (int k = 0; k < 3; k++) begin
      stepRand();
      div = edges[k] | {7'h00, rnd[7:0]};
      br = 5'(rnd[15:8] % 29);
      wrTx(devW, '{{1'b0, div[14:8]}, div[7:0], 8'h80, {3'b100, br}}, 1'b1);
      check("prog divider", progDivider, div);
      check("ref ratio", synthRefRatio, br);
      check("band", loBand, bands[k]);
      check("port zero", portZeroOe, 1'b1);
    end
    stepRand();
    bw = 6'(rnd[5:0] % 63);
    wrTx(devW, '{8'hC1, {1'b1, bw, 1'b0}}, 1'b1);
    check("bypass off", {bypassEnable, bypassPowerDown, portOneOe}, 3'b011);
    check("bandwidth", filterBandwidthField, bw);
    standbyIn = 1'b1;
    lockIn = 1'b0;
    cyc(8);
    check("standby", {analogPowerDown, bypassEnable, lockPin}, 3'b100);
    rdTx(1, 8'h30);
    wrTx(devW, '{8'hC0, {1'b0, bw, 1'b0}}, 1'b1);
    check("bypass on", {bypassEnable, bypassPowerDown, portOneOe}, 3'b100);
    standbyIn = 1'b0;
    br = 5'(4 + rnd[12:8] % 24);
    wrTx(devW, '{8'hF0, {1'b1, br, 2'b00}, 8'hFF}, 1'b1);
    check("power down bit", analogPowerDown, 1'b1);
    check("filter ref", filterRefDivider, br);
    check("extra byte", progDivider, div);
    wrTx(devW, '{8'hF0, 8'h28}, 1'b1);
    check("power up", analogPowerDown, 1'b0);
    supplyFailIn = 1'b1;
    cyc(4);
    supplyFailIn = 1'b0;
    cyc(8);
    check("supply fail", tunerStatus[7], 1'b1);
    check("reloaded", {progDivider, portZeroOe, filterRefDivider}, {15'h0000, 1'b0, 5'h0A});
    check("queue empty", 16'(expQ.size()), 16'h0000);
    reportAndStop();
  end
endmodule
